// File: core/video_line_timing.sv
// Programmable sync and blanking interval generator with an APB register
// file. Assumes an APB master on pclk; all video outputs are registered.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "line_timing_params.svh"

// How it works
// R1: sync tip lasts tip_pulse_width cycles
// R2: gap after tip lasts gap_after_tip_len
// R3: chroma burst lasts chroma_ref_len cycles
// R4: colour back porch lasts color_porch_len
// R5: wide porch is 10-bit, low byte separate
// R6: active region is 10-bit, low byte separate
// R7: two half-line actives, 10-bit each
// R8: equalizer low lasts equalizer_low_len cycles
// R9: equalizer high is value plus 256/512
// R10: vertical tip low is value plus 256/512
// R11: vertical tip high has no offset
// R12: front porch lasts front_porch_len cycles
// R13: offset_select_bit low adds 256, high 512
// R14: top two bits from shared byte register
// R15: segments run back to back, counted
module video_line_timing (
  input  wire logic                         pclk,     // 200 MHz clock
  input  wire logic                         presetn,  // async reset
  input  wire line_timing_pkg::apb_req_type apb_req,  // APB request
  output line_timing_pkg::apb_rsp_type      apb_rsp,  // APB answer
  output line_timing_pkg::video_out_type    vid       // sync and gates
);

  line_timing_pkg::state_type s;
  line_timing_pkg::state_type next_s;

  // ========================================================================
  // Helpers

  function automatic logic [9:0] offset_len(
    input logic [7:0] low,
    input logic       sel
  );
    logic [9:0] base;
    base = sel ? `OFFSET_HIGH : `OFFSET_LOW;          // R13
    return base + {2'b00, low};                       // R9 R10
  endfunction

  function automatic logic [9:0] wide_len(
    input logic [7:0] low,
    input logic [7:0] msb,
    input int         pos
  );
    return {msb[pos+1 -: 2], low};                    // R14
  endfunction

  function automatic logic [9:0] seg_len(
    input line_timing_pkg::segment_type seg,
    input line_timing_pkg::state_type   st
  );
    logic [9:0] r;
    r = 10'h000;
    unique case (seg)
      line_timing_pkg::seg_idle:
        r = 10'h000;
      line_timing_pkg::seg_tip:
        r = {2'b00, st.len[0]};                       // R1
      line_timing_pkg::seg_gap:
        r = {2'b00, st.len[1]};                       // R2
      line_timing_pkg::seg_chroma:
        r = {2'b00, st.len[2]};                       // R3
      line_timing_pkg::seg_porch:
        r = {2'b00, st.len[3]};                       // R4
      line_timing_pkg::seg_wide_porch:
        r = wide_len(st.len[4], st.len_msb,
                     `MSB_WIDE_PORCH_POS);            // R5
      line_timing_pkg::seg_active:
        r = wide_len(st.len[5], st.len_msb,
                     `MSB_ACTIVE_POS);                // R6
      line_timing_pkg::seg_second_half:
        r = wide_len(st.len[6], st.len_msb,
                     `MSB_SECOND_HALF_POS);           // R7
      line_timing_pkg::seg_first_half:
        r = wide_len(st.len[7], st.len_msb,
                     `MSB_FIRST_HALF_POS);            // R7
      line_timing_pkg::seg_eq_low:
        r = {2'b00, st.len[8]};                       // R8
      line_timing_pkg::seg_eq_high:
        r = offset_len(st.len[9], st.offset_select_bit);
      line_timing_pkg::seg_vtip_low:
        r = offset_len(st.len[10], st.offset_select_bit);
      line_timing_pkg::seg_vtip_high:
        r = {2'b00, st.len[11]};                      // R11
      line_timing_pkg::seg_front:
        r = {2'b00, st.len[12]};                      // R12
    endcase
    return r;
  endfunction

  // The mode is looked at only when a segment ends, so a mode change never
  // cuts a segment short.
  function automatic line_timing_pkg::segment_type seg_next(
    input line_timing_pkg::segment_type   seg,
    input line_timing_pkg::line_mode_type mode
  );
    line_timing_pkg::segment_type n;
    n = line_timing_pkg::seg_tip;
    unique case (seg)
      line_timing_pkg::seg_tip:
        n = line_timing_pkg::seg_gap;
      line_timing_pkg::seg_gap:
        n = line_timing_pkg::seg_chroma;
      line_timing_pkg::seg_chroma:
        n = (mode == line_timing_pkg::mode_wide_porch) ?
            line_timing_pkg::seg_wide_porch : line_timing_pkg::seg_porch;
      line_timing_pkg::seg_porch,
      line_timing_pkg::seg_wide_porch:
        n = (mode == line_timing_pkg::mode_half_line) ?
            line_timing_pkg::seg_first_half : line_timing_pkg::seg_active;
      line_timing_pkg::seg_first_half:
        n = line_timing_pkg::seg_second_half;
      line_timing_pkg::seg_active,
      line_timing_pkg::seg_second_half:
        n = line_timing_pkg::seg_front;
      line_timing_pkg::seg_eq_low:
        n = line_timing_pkg::seg_eq_high;
      line_timing_pkg::seg_eq_high:
        n = line_timing_pkg::seg_vtip_low;
      line_timing_pkg::seg_vtip_low:
        n = line_timing_pkg::seg_vtip_high;
      line_timing_pkg::seg_idle,
      line_timing_pkg::seg_front,
      line_timing_pkg::seg_vtip_high:
        n = (mode == line_timing_pkg::mode_vertical) ?
            line_timing_pkg::seg_eq_low : line_timing_pkg::seg_tip;
    endcase
    return n;
  endfunction

  function automatic line_timing_pkg::video_out_type seg_video(
    input line_timing_pkg::segment_type seg
  );
    line_timing_pkg::video_out_type v;
    v.sync_n = !(seg == line_timing_pkg::seg_tip ||
                 seg == line_timing_pkg::seg_eq_low ||
                 seg == line_timing_pkg::seg_vtip_low);
    v.burst_gate = (seg == line_timing_pkg::seg_chroma);
    v.active_video = (seg == line_timing_pkg::seg_active ||
                      seg == line_timing_pkg::seg_first_half ||
                      seg == line_timing_pkg::seg_second_half);
    v.vertical_interval = (seg == line_timing_pkg::seg_eq_low ||
                           seg == line_timing_pkg::seg_eq_high ||
                           seg == line_timing_pkg::seg_vtip_low ||
                           seg == line_timing_pkg::seg_vtip_high);
    return v;
  endfunction

  // ========================================================================
  // Register decode

  // The thirteen length bytes sit at consecutive indices. One range test
  // and one subtraction serve the read mux, the write path and the map, so
  // the three can never disagree about where a length lives.
  function automatic logic is_len_idx(input logic [9:0] idx);
    return idx >= 10'(`IDX_TIP_PULSE_WIDTH) &&
           idx <= 10'(`IDX_FRONT_PORCH_LEN);
  endfunction

  function automatic logic [3:0] len_slot(input logic [9:0] idx);
    logic [9:0] rel;
    rel = idx - 10'(`IDX_TIP_PULSE_WIDTH);
    return rel[3:0];
  endfunction

  // ========================================================================
  // Register read mux

  function automatic logic [31:0] read_word(
    input logic [9:0]                 idx,
    input line_timing_pkg::state_type st
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    if (is_len_idx(idx)) begin
      r[7:0] = st.len[len_slot(idx)];
    end else if (idx == 10'(`IDX_LEN_MSB)) begin
      r[7:0] = st.len_msb;
    end else if (idx == 10'(`IDX_VERT_CTRL)) begin
      r[`OFFSET_SELECT_POS] = st.offset_select_bit;
    end else if (idx == 10'(`IDX_GEN_CTRL)) begin
      r[`CTRL_RUN_POS] = st.run;
      r[`CTRL_MODE_POS +: 2] = st.mode;
    end else if (idx == 10'(`IDX_GEN_STATUS)) begin
      r[3:0] = st.seg;
      r[`STATUS_RUN_POS] = (st.seg != line_timing_pkg::seg_idle);
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [9:0] idx);
    return is_len_idx(idx) ||
           idx == 10'(`IDX_LEN_MSB) ||
           idx == 10'(`IDX_VERT_CTRL) ||
           idx == 10'(`IDX_GEN_CTRL) ||
           idx == 10'(`IDX_GEN_STATUS);
  endfunction

  // ========================================================================
  // Next state

  logic [9:0] reg_idx;
  logic       access;
  logic       word_ok;
  logic [9:0] cur_len;

  assign reg_idx = apb_req.paddr[11:2];
  assign access  = apb_req.psel && apb_req.penable;
  assign word_ok = (apb_req.paddr[1:0] == 2'b00) && mapped(reg_idx);
  assign cur_len = seg_len(s.seg, s);

  always_comb begin
    next_s = s;

    // Bus slave: one wait state, the answer is prepared while pready is
    // low and the write lands at the edge that sees pready high.
    // The error flag falls with pready, so it never outlives its transfer.
    next_s.rsp.pready  = access && !s.rsp.pready;
    next_s.rsp.pslverr = 1'b0;
    if (access && !s.rsp.pready) begin
      next_s.rsp.pslverr = !word_ok;
      next_s.rsp.prdata  = (apb_req.pwrite || !word_ok) ?
                           32'h0000_0000 : read_word(reg_idx, s);
    end
    if (access && s.rsp.pready && apb_req.pwrite && word_ok) begin
      if (is_len_idx(reg_idx)) begin
        next_s.len[len_slot(reg_idx)] = apb_req.pwdata[7:0];
      end else if (reg_idx == 10'(`IDX_LEN_MSB)) begin
        next_s.len_msb = apb_req.pwdata[7:0];         // R14
      end else if (reg_idx == 10'(`IDX_VERT_CTRL)) begin
        next_s.offset_select_bit = apb_req.pwdata[`OFFSET_SELECT_POS];
      end else if (reg_idx == 10'(`IDX_GEN_CTRL)) begin
        next_s.run  = apb_req.pwdata[`CTRL_RUN_POS];
        next_s.mode = line_timing_pkg::line_mode_type'(
                        apb_req.pwdata[`CTRL_MODE_POS +: 2]);
      end
    end

    // Segment sequencer. A zero length still spends one cycle in its
    // segment; skipping it in the same cycle would need a priority chain
    // across every later segment and buys nothing on a real line.
    // A length rewritten shorter in mid-segment ends that segment at once;
    // a test for equality would let the counter run on until it wrapped.
    if (!s.run) begin
      next_s.seg   = line_timing_pkg::seg_idle;
      next_s.count = 10'h000;
    end else if (s.seg == line_timing_pkg::seg_idle ||
                 cur_len == 10'h000 ||
                 s.count >= cur_len - 10'h001) begin
      next_s.seg   = seg_next(s.seg, s.mode);         // R15
      next_s.count = 10'h000;
    end else begin
      next_s.count = s.count + 10'h001;               // R15
    end

    next_s.vid = seg_video(next_s.seg);               // R1 R3 R8 R10
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.len               <= {13{`LEN_RESET}};
      s.len_msb           <= `LEN_RESET;
      s.offset_select_bit <= 1'b0;
      s.run               <= 1'b0;
      s.mode              <= line_timing_pkg::mode_normal;
      s.seg               <= line_timing_pkg::seg_idle;
      s.count             <= 10'h000;
      s.rsp               <= '0;
      s.vid               <= 4'b1000;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp = s.rsp;
  assign vid     = s.vid;

endmodule

// File: core/line_timing_params.svh
// Register indices, field positions, reset values and offsets of the
// line timing generator. Assumes APB byte address = 4 * register index.
`ifndef LINE_TIMING_PARAMS_SVH
`define LINE_TIMING_PARAMS_SVH

// ==========================================================================
// Register indices
`define IDX_VERT_CTRL        8'h19
`define IDX_TIP_PULSE_WIDTH  8'h20
`define IDX_GAP_AFTER_TIP    8'h21
`define IDX_CHROMA_REF_LEN   8'h22
`define IDX_COLOR_PORCH_LEN  8'h23
`define IDX_WIDE_PORCH_LOW   8'h24
`define IDX_ACTIVE_LOW       8'h25
`define IDX_SECOND_HALF_LOW  8'h26
`define IDX_FIRST_HALF_LOW   8'h27
`define IDX_EQ_LOW_LEN       8'h28
`define IDX_EQ_HIGH_LEN      8'h29
`define IDX_VTIP_LOW_LEN     8'h2a
`define IDX_VTIP_HIGH_LEN    8'h2b
`define IDX_FRONT_PORCH_LEN  8'h2c
`define IDX_LEN_MSB          8'h2d
`define IDX_GEN_CTRL         8'h40
`define IDX_GEN_STATUS       8'h41

// ==========================================================================
// Field positions
`define OFFSET_SELECT_POS    6
`define MSB_WIDE_PORCH_POS   6
`define MSB_ACTIVE_POS       4
`define MSB_FIRST_HALF_POS   2
`define MSB_SECOND_HALF_POS  0
`define CTRL_RUN_POS         0
`define CTRL_MODE_POS        1
`define STATUS_RUN_POS       7

// ==========================================================================
// Reset values and fixed offsets
`define LEN_RESET            8'h00
`define CTRL_RESET           8'h00
`define OFFSET_LOW           10'h100
`define OFFSET_HIGH          10'h200

`endif

// File: core/line_timing_pkg.sv
// Types of the line timing generator: bus carriers, modes, segments and
// the single state record of the generator.
package line_timing_pkg;

  // ========================================================================
  // APB carriers and video outputs
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic sync_n;
    logic burst_gate;
    logic active_video;
    logic vertical_interval;
  } video_out_type;

  // ========================================================================
  // Line modes and segments
  typedef enum logic [1:0] {
    mode_normal,
    mode_wide_porch,
    mode_half_line,
    mode_vertical
  } line_mode_type;

  typedef enum logic [3:0] {
    seg_idle,
    seg_tip,
    seg_gap,
    seg_chroma,
    seg_porch,
    seg_wide_porch,
    seg_active,
    seg_first_half,
    seg_second_half,
    seg_front,
    seg_eq_low,
    seg_eq_high,
    seg_vtip_low,
    seg_vtip_high
  } segment_type;

  // ========================================================================
  // Whole state of the generator
  typedef struct packed {
    logic [12:0][7:0] len;
    logic [7:0]       len_msb;
    logic             offset_select_bit;
    logic             run;
    line_mode_type    mode;
    segment_type      seg;
    logic [9:0]       count;
    apb_rsp_type      rsp;
    video_out_type    vid;
  } state_type;

endpackage

// File: testbench/line_timing_asserts.sv
// Checker of the interval generator's ports.
// Assumes it is bound to video_line_timing below.
`timescale 1ns/1ps
module line_timing_asserts (
  input wire logic                         pclk,    // clock
  input wire logic                         presetn, // async reset
  input wire line_timing_pkg::apb_req_type apb_req, // APB request
  input wire line_timing_pkg::apb_rsp_type apb_rsp, // APB answer
  input wire line_timing_pkg::video_out_type vid    // video outputs
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Bus
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence
  property p_wait; s_setup ##1 s_access |=> apb_rsp.pready; endproperty
  a_wait: assert property (p_wait) else $error("late pready");
  property p_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_cause;
    apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable);
  endproperty
  a_cause: assert property (p_cause) else $error("pready uncaused");
  property p_err; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
  a_err: assert property (p_err) else $error("stray pslverr");
  property p_upper; apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  // ==========================================================
  // Line segments
  property p_gap;
    $rose(vid.sync_n) && !vid.vertical_interval |-> !vid.burst_gate;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap after tip");
  property p_porch; $fell(vid.burst_gate) |-> !vid.active_video; endproperty
  a_porch: assert property (p_porch) else $error("no porch");
  property p_front;
    $fell(vid.active_video) && !vid.vertical_interval |-> vid.sync_n;
  endproperty
  a_front: assert property (p_front) else $error("no front porch");
  property p_solo;
    !vid.sync_n |-> !vid.burst_gate && !vid.active_video;
  endproperty
  a_solo: assert property (p_solo) else $error("segments overlap");
  property p_vert;
    vid.vertical_interval |-> !vid.burst_gate && !vid.active_video;
  endproperty
  a_vert: assert property (p_vert) else $error("video in vertical");
endmodule
bind video_line_timing line_timing_asserts line_timing_asserts_inst (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .vid(vid));

// File: testbench/video_sink.sv
// Display side model: measures runs of the sync and gate outputs.
// Assumes clr is pulsed by the bench before each measurement.
`timescale 1ns/1ps
module video_sink (
  input  wire logic                           pclk,       // clock
  input  wire logic                           presetn,    // sync reset
  input  wire logic                           clr,        // restart
  input  wire line_timing_pkg::video_out_type vid,        // from encoder
  output logic [10:0]                         lo_min,     // sync low
  output logic [10:0]                         lo_max,     // sync low
  output logic [10:0]                         hi_min,     // sync high
  output logic [10:0]                         hi_max,     // sync high
  output logic [10:0]                         burst_len,  // last burst
  output logic [10:0]                         porch_len,  // last porch
  output logic [10:0]                         active_len, // last active
  output logic [7:0]                          runs        // full runs
);
  line_timing_pkg::video_out_type prev;
  logic [10:0] run, bcnt, pcnt, acnt;
  logic        on;
  // The first run after clr started in idle, so it is never recorded.
  // Reset and clear both act at the clock edge; reset is held for many.
  always_ff @(posedge pclk) begin
    if (!presetn || clr) begin
      {lo_max, hi_max, burst_len, porch_len, active_len} <= '0;
      {lo_min, hi_min} <= '1;
      {runs, run, bcnt, pcnt, acnt, on} <= '0;
      prev <= 4'b1000;
    end else begin
      prev <= vid;
      run <= (vid.sync_n == prev.sync_n) ? run + 11'd1 : 11'd1;
      if (vid.sync_n != prev.sync_n) begin
        on <= 1'b1;
        if (on && prev.sync_n) begin
          hi_min <= (run < hi_min) ? run : hi_min;
          hi_max <= (run > hi_max) ? run : hi_max;
        end
        if (on && !prev.sync_n) begin
          lo_min <= (run < lo_min) ? run : lo_min;
          lo_max <= (run > lo_max) ? run : lo_max;
        end
        if (on) runs <= runs + 8'd1;
      end
      bcnt <= vid.burst_gate ? bcnt + 11'd1 : 11'd0;
      pcnt <= vid.burst_gate ? 11'd0 : pcnt + 11'd1;
      acnt <= vid.active_video ? acnt + 11'd1 : 11'd0;
      if (prev.burst_gate && !vid.burst_gate) burst_len <= bcnt;
      if (vid.active_video && !prev.active_video) porch_len <= pcnt;
      if (prev.active_video && !vid.active_video) active_len <= acnt;
    end
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench of the interval generator.
// Assumes the design header and package are compiled first.
`timescale 1ns/1ps
`include "line_timing_params.svh"
module tb;
  logic                           pclk;
  logic                           presetn;
  logic                           clr;
  line_timing_pkg::apb_req_type   req;
  line_timing_pkg::apb_rsp_type   rsp;
  line_timing_pkg::video_out_type vid;
  logic [10:0] lo_min, lo_max, hi_min, hi_max, bl, pl, al;
  logic [7:0]  runs;
  logic [31:0] q;
  logic        e;
  int          failures;
  int          tests_run;
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic       err;
  } row_type;
  row_type rows [7];
  video_line_timing video_line_timing_inst (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .vid(vid));
  video_sink video_sink_inst (.pclk(pclk), .presetn(presetn), .clr(clr),
    .vid(vid), .lo_min(lo_min), .lo_max(lo_max), .hi_min(hi_min),
    .hi_max(hi_max), .burst_len(bl), .porch_len(pl), .active_len(al),
    .runs(runs));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, g);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h0, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      test_done();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Stop, clear the sink while idle, then run in the given mode.
  task automatic go(input logic [7:0] ctrl, input int k);
    int n;
    apb(1'b1, `IDX_GEN_CTRL, 8'h00);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    apb(1'b1, `IDX_GEN_CTRL, ctrl);
    for (n = 0; n < 5000 && runs < k; n++) @(posedge pclk);
    if (n >= 5000) begin
      failures++;
      test_done();
    end
  endtask
  initial begin
    presetn = 1'b0;
    clr = 1'b0;
    req = '0;
    rows = '{'{10'h020, 8'ha5, 8'ha5, 1'b0}, '{10'h02d, 8'hc3, 8'hc3, 1'b0},
             '{10'h019, 8'hff, 8'h40, 1'b0}, '{10'h030, 8'h11, 8'h00, 1'b1},
             '{10'h024, 8'h5a, 8'h5a, 1'b0}, '{10'h040, 8'h06, 8'h06, 1'b0},
             '{10'h041, 8'hff, 8'h00, 1'b0}};
    repeat (16) @(posedge pclk);
    chk("sync_n", 1, vid.sync_n);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `IDX_FRONT_PORCH_LEN, 8'h00);
    chk("reset value", 0, q);
    foreach (rows[k]) begin
      apb(1'b1, rows[k].idx, rows[k].wd);
      apb(1'b0, rows[k].idx, 8'h00);
      chk("read data", rows[k].rd, q);
      chk("pslverr", rows[k].err, e);
    end
    $display("register table done");
    apb(1'b1, `IDX_TIP_PULSE_WIDTH, 8'h03);
    apb(1'b1, `IDX_GAP_AFTER_TIP, 8'h02);
    apb(1'b1, `IDX_CHROMA_REF_LEN, 8'h04);
    apb(1'b1, `IDX_COLOR_PORCH_LEN, 8'h02);
    apb(1'b1, `IDX_ACTIVE_LOW, 8'h05);
    apb(1'b1, `IDX_LEN_MSB, 8'h58);
    apb(1'b1, `IDX_FRONT_PORCH_LEN, 8'h02);
    go(8'h01, 3);
    chk("tip", 3, lo_max);
    chk("line rest", 2 + 4 + 2 + 261 + 2, hi_max);
    chk("burst", 4, bl);
    chk("porch", 2, pl);
    chk("active", 261, al);
    chk("vertical gate", 0, vid.vertical_interval);
    apb(1'b0, `IDX_GEN_STATUS, 8'h00);
    chk("running", 1, q[7]);
    apb(1'b1, `IDX_WIDE_PORCH_LOW, 8'h09);
    go(8'h03, 3);
    chk("wide porch", 265, pl);
    $display("normal and wide lines done");
    apb(1'b1, `IDX_CHROMA_REF_LEN, 8'h00);
    apb(1'b1, `IDX_FIRST_HALF_LOW, 8'h03);
    apb(1'b1, `IDX_SECOND_HALF_LOW, 8'h07);
    go(8'h05, 3);
    chk("short burst", 1, bl);
    chk("half lines", 515 + 7, al);
    $display("half lines done");
    apb(1'b1, `IDX_VERT_CTRL, 8'h00);
    apb(1'b1, `IDX_EQ_LOW_LEN, 8'h04);
    apb(1'b1, `IDX_EQ_HIGH_LEN, 8'h02);
    apb(1'b1, `IDX_VTIP_LOW_LEN, 8'h01);
    apb(1'b1, `IDX_VTIP_HIGH_LEN, 8'h03);
    go(8'h07, 5);
    chk("eq low", 4, lo_min);
    chk("vtip low", 256 + 1, lo_max);
    chk("vtip high", 3, hi_min);
    chk("eq high", 256 + 2, hi_max);
    chk("vertical gate", 1, vid.vertical_interval);
    apb(1'b1, `IDX_VERT_CTRL, 8'h40);
    go(8'h07, 5);
    chk("vtip low 512", 512 + 1, lo_max);
    chk("eq high 512", 512 + 2, hi_max);
    $display("vertical interval done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("sync_n", 1, vid.sync_n);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `IDX_EQ_HIGH_LEN, 8'h00);
    chk("reset value", 0, q);
    $display("second reset done");
    test_done();
  end
endmodule
